/* common/dsf_pkg.sv */
// Constants and types shared by the driver status flag block.
// Assumes one clock domain and a 7-bit register address from the serial link.
package dsf_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [ADDR_W-1:0] ADDR_DRIVER_STATUS_FLAGS = 7'h6F;
	localparam int DATA_W = 32;
	localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field positions of the status word
	// ------------------------------------------------------------
	localparam int BIT_STANDSTILL = 31;
	localparam int BIT_QUIET_CHOP = 30;
	localparam int CS_LO = 16;
	localparam int CS_W = 5;
	localparam int TEMP_LO = 8;
	localparam int TEMP_W = 4;
	localparam int BIT_OPEN_LOAD_B = 7;
	localparam int BIT_OPEN_LOAD_A = 6;
	localparam int SHORT_LO = 2;
	localparam int SHORT_W = 4;
	localparam int BIT_OVERHEAT = 1;
	localparam int BIT_PREWARN = 0;

	// Order inside the short vector: lowside B, lowside A, ground B, ground A.
	// Order inside the temperature vector: top, high, mid, low.

	// ------------------------------------------------------------
	// Timing and configuration
	// ------------------------------------------------------------
	localparam int unsigned STANDSTILL_CYCLES_DEFAULT = 2 ** 20;
	localparam int OFF_TIME_W = 4;
	localparam logic [OFF_TIME_W-1:0] OFF_TIME_DISABLED = 4'h0;
	localparam int SYNC_W = 10;
	// Enable pin is active low, so its synchroniser resets to the disabled level.
	localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h100;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DSF_OT_COOL = 2'b00,
		DSF_OT_HOT = 2'b01,
		DSF_OT_WAIT = 2'b10
	} dsf_ot_state_t;

endpackage

/* common/dsf_if.sv */
// Carrier between the status flag block and its standstill timer.
// Assumes both ends run on the same clock.
interface dsf_if;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic stepSeen;
	logic standstill;

	modport ctrl (
		output stepSeen,
		input standstill
	);

	modport timer (
		input stepSeen,
		output standstill
	);

endinterface

/* design/dsf_standstill_timer.sv */
// Standstill timer: counts clock cycles since the most recent step pulse.
// Assumes the step pulse is already synchronised and one cycle long.
module dsf_standstill_timer
	import dsf_pkg::*;
#(
	parameter int unsigned CYCLES = dsf_pkg::STANDSTILL_CYCLES_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	dsf_if.timer link
);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic atLimit;

	assign atLimit = (count == LIMIT);
	assign next_count = link.stepSeen ? '0 : (atLimit ? count : count + ONE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			link.standstill <= 1'b0;
		end else begin
			count <= next_count;
			link.standstill <= (next_count == LIMIT);
		end
	end

endmodule

/* design/dsf_driver_status_flags.sv */
// Driver status flags: the read-only status word of a two-phase stepper driver.
// Assumes chopper setting, current scale and open-load flags come from logic on ref_clk,
// while pins and analog comparators arrive asynchronously.
module dsf_driver_status_flags
	import dsf_pkg::*;
#(
	parameter int unsigned STANDSTILL_CYCLES = dsf_pkg::STANDSTILL_CYCLES_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic stepPin,
	input wire logic driverEnablePinN,
	input wire logic [dsf_pkg::OFF_TIME_W-1:0] chopperOffTime,
	input wire logic quietChopper,
	input wire logic [dsf_pkg::CS_W-1:0] csActual,
	input wire logic otSelect,
	input wire logic tempLevelTop,
	input wire logic tempLevelHigh,
	input wire logic tempLevelMid,
	input wire logic tempLevelLow,
	input wire logic lowsideShortPhaseB,
	input wire logic lowsideShortPhaseA,
	input wire logic groundShortPhaseB,
	input wire logic groundShortPhaseA,
	input wire logic openLoadPhaseB,
	input wire logic openLoadPhaseA,
	input wire logic [dsf_pkg::ADDR_W-1:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	output logic [dsf_pkg::DATA_W-1:0] regRdata,
	output logic regRvalid,
	output logic regWack,
	output logic bridgeEnable
);
	import dsf_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Next value of one short flag set; a detection wins over a clear.
	function automatic logic [SHORT_W-1:0] nextShorts(
		input logic [SHORT_W-1:0] cur,
		input logic [SHORT_W-1:0] det,
		input logic clr,
		input logic active
	);
		logic [SHORT_W-1:0] kept;
		kept = clr ? '0 : cur;
		return active ? (kept | det) : kept;
	endfunction

	// Picks the comparator output that belongs to the selected limit.
	function automatic logic pickLevel(
		input logic sel,
		input logic whenSet,
		input logic whenClear
	);
		return sel ? whenSet : whenClear;
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] asyncIn;
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;

	assign asyncIn = {
		stepPin,
		driverEnablePinN,
		tempLevelTop,
		tempLevelHigh,
		tempLevelMid,
		tempLevelLow,
		lowsideShortPhaseB,
		lowsideShortPhaseA,
		groundShortPhaseB,
		groundShortPhaseA
	};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= SYNC_RESET;
			syncB <= SYNC_RESET;
		end else begin
			syncA <= asyncIn;
			syncB <= syncA;
		end
	end

	// ------------------------------------------------------------
	// Named synchronised inputs
	// ------------------------------------------------------------
	logic stepSync;
	logic enablePinNSync;
	logic [TEMP_W-1:0] tempLevels;
	logic [SHORT_W-1:0] shortSeen;

	assign stepSync = syncB[9];
	assign enablePinNSync = syncB[8];
	assign tempLevels = syncB[7:4];
	assign shortSeen = syncB[3:0];

	// ------------------------------------------------------------
	// Step edge and standstill timer
	// ------------------------------------------------------------
	logic stepPrev;
	logic stepRise;

	dsf_if link ();

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stepPrev <= 1'b0;
		end else begin
			stepPrev <= stepSync;
		end
	end

	assign stepRise = stepSync & ~stepPrev;
	assign link.stepSeen = stepRise;

	dsf_standstill_timer #(
		.CYCLES(STANDSTILL_CYCLES)
	) standstillTimer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.link(link.timer)
	);

	// ------------------------------------------------------------
	// Temperature levels
	// ------------------------------------------------------------
	logic overtempHit;
	logic prewarnHit;

	assign overtempHit = pickLevel(otSelect, tempLevels[2], tempLevels[3]);
	assign prewarnHit = pickLevel(otSelect, tempLevels[1], tempLevels[0]);

	// ------------------------------------------------------------
	// Overheat state machine
	// ------------------------------------------------------------
	dsf_ot_state_t otState;
	dsf_ot_state_t next_otState;
	logic overheatFlag;
	logic overheatBlock;

	always_comb begin
		next_otState = otState;
		unique case (otState)
			DSF_OT_COOL: begin
				if (overtempHit) begin
					next_otState = DSF_OT_HOT;
				end
			end
			DSF_OT_HOT: begin
				if (!overtempHit) begin
					next_otState = DSF_OT_WAIT;
				end
			end
			DSF_OT_WAIT: begin
				if (overtempHit) begin
					next_otState = DSF_OT_HOT;
				end else if (!prewarnHit) begin
					next_otState = DSF_OT_COOL;
				end
			end
			default: begin
				next_otState = DSF_OT_HOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			otState <= DSF_OT_COOL;
		end else begin
			otState <= next_otState;
		end
	end

	// One flag for both bridges.
	assign overheatFlag = (otState != DSF_OT_COOL);
	assign overheatBlock = overheatFlag;

	// ------------------------------------------------------------
	// Short flags, one set per chopper scheme
	// ------------------------------------------------------------
	logic [SHORT_W-1:0] shortsQuiet;
	logic [SHORT_W-1:0] shortsCurrent;
	logic [SHORT_W-1:0] shortDetect;
	logic [SHORT_W-1:0] shortsShown;
	logic shortClear;
	logic anyShort;

	// A short can only be seen while the bridges drive.
	assign shortDetect = shortSeen & {SHORT_W{bridgeEnable}};
	assign shortClear = (chopperOffTime == OFF_TIME_DISABLED) | enablePinNSync;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shortsQuiet <= '0;
			shortsCurrent <= '0;
		end else begin
			shortsQuiet <= nextShorts(shortsQuiet, shortDetect, shortClear, quietChopper);
			shortsCurrent <= nextShorts(shortsCurrent, shortDetect, shortClear, ~quietChopper);
		end
	end

	assign shortsShown = quietChopper ? shortsQuiet : shortsCurrent;
	assign anyShort = |{shortsQuiet, shortsCurrent};

	// ------------------------------------------------------------
	// Bridge enable
	// ------------------------------------------------------------
	logic next_bridgeEnable;

	// Open-load flags take no part in this decision.
	assign next_bridgeEnable = ~enablePinNSync
		& (chopperOffTime != OFF_TIME_DISABLED)
		& ~anyShort
		& ~overheatBlock;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bridgeEnable <= 1'b0;
		end else begin
			bridgeEnable <= next_bridgeEnable;
		end
	end

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	logic [DATA_W-1:0] statusWord;

	always_comb begin
		statusWord = STATUS_RESET;
		statusWord[BIT_STANDSTILL] = link.standstill;
		statusWord[BIT_QUIET_CHOP] = quietChopper;
		statusWord[CS_LO +: CS_W] = csActual;
		statusWord[TEMP_LO +: TEMP_W] = tempLevels;
		statusWord[BIT_OPEN_LOAD_B] = openLoadPhaseB;
		statusWord[BIT_OPEN_LOAD_A] = openLoadPhaseA;
		statusWord[SHORT_LO +: SHORT_W] = shortsShown;
		statusWord[BIT_OVERHEAT] = overheatFlag;
		statusWord[BIT_PREWARN] = prewarnHit;
	end

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	logic addrHit;
	logic readHit;
	logic writeHit;

	assign addrHit = (regAddr == ADDR_DRIVER_STATUS_FLAGS);
	assign readHit = regRead & addrHit;
	// A write without a read in the same cycle is acknowledged but stores nothing.
	assign writeHit = regWrite & addrHit & ~regRead;

	// Read data fall back to zero between answers.
	logic [DATA_W-1:0] next_regRdata;

	assign next_regRdata = readHit ? statusWord : STATUS_RESET;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= STATUS_RESET;
		end else begin
			regRdata <= next_regRdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= readHit;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regWack <= 1'b0;
		end else begin
			regWack <= writeHit;
		end
	end

endmodule

/* dv/dsf_driver_status_flags_assertions.sv */
// Checker for the driver status flag block.
// Assumes it is bound to the top module and sees only its ports.
module dsf_driver_status_flags_assertions
	import dsf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] chopperOffTime,
	input wire logic quietChopper,
	input wire logic [4:0] csActual,
	input wire logic openLoadPhaseB,
	input wire logic openLoadPhaseA,
	input wire logic [6:0] regAddr,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [31:0] regRdata,
	input wire logic regRvalid,
	input wire logic regWack,
	input wire logic bridgeEnable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic readHit;
	assign readHit = regRead && regAddr == ADDR_DRIVER_STATUS_FLAGS;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (readHit |=> regRvalid)
		else $error("read not answered");
	a_valid_cause: assert property (regRvalid |-> $past(readHit))
		else $error("answer without read");
	a_reserved_zero: assert property (regRvalid |-> !(|regRdata[29:21]) && !(|regRdata[15:12]))
		else $error("reserved bits set");
	a_mode_scale: assert property (regRvalid |->
		regRdata[30] == $past(quietChopper) && regRdata[20:16] == $past(csActual))
		else $error("mode or scale wrong");
	a_openload_raw: assert property (regRvalid |->
		regRdata[7:6] == {$past(openLoadPhaseB), $past(openLoadPhaseA)})
		else $error("open load bits wrong");
	a_write_quiet: assert property (regWrite && !regRead &&
		regAddr == ADDR_DRIVER_STATUS_FLAGS |=> regWack && !regRvalid)
		else $error("write not acknowledged");
	a_offtime_stop: assert property (chopperOffTime == 4'h0 |=> !bridgeEnable)
		else $error("bridge on with zero off time");
	a_short_stop: assert property (regRvalid && |regRdata[5:2] |-> ##[0:2] !bridgeEnable)
		else $error("bridge on after short");
	a_overheat_stop: assert property (regRvalid && regRdata[1] |-> ##[0:2] !bridgeEnable)
		else $error("bridge on while overheated");
endmodule

/* dv/dsf_host_model.sv */
// Host model: reads and writes the status word and owns the off-time setting.
// Assumes one-cycle strobes answered one cycle after the taking edge.
module dsf_host_model
	import dsf_pkg::*;
(
	input wire logic ref_clk,
	output logic [6:0] regAddr,
	output logic regRead,
	output logic regWrite,
	output logic [3:0] chopperOffTime,
	input wire logic [31:0] regRdata,
	input wire logic regRvalid,
	input wire logic regWack
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regAddr = 7'h00;
		regRead = 1'b0;
		regWrite = 1'b0;
		chopperOffTime = 4'h3;
	end
	task automatic access(input logic [6:0] a, input logic wr, output logic [31:0] d,
		output logic ok);
		ok = 1'b0;
		d = 32'h0;
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= !wr;
		regWrite <= wr;
		@(posedge ref_clk);
		regRead <= 1'b0;
		regWrite <= 1'b0;
		regAddr <= ~a;
		repeat (3) begin
			@(posedge ref_clk);
			if (!ok && (wr ? regWack : regRvalid) === 1'b1) begin
				ok = 1'b1;
				d = regRdata;
			end
		end
	endtask
	// A zero off time is how the host clears latched shorts.
	task automatic setOffTime(input logic [3:0] t);
		@(posedge ref_clk);
		chopperOffTime <= t;
	endtask
endmodule

/* dv/dsf_driver_status_flags_tb.sv */
// Self-checking bench for the driver status flag block.
// Assumes the host model owns the register port and the off-time setting.
module dsf_driver_status_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dsf_pkg::*;
	localparam int SS = 64;
	logic ref_clk, rst_n, stepPin, driverEnablePinN, quietChopper, otSelect, ok;
	logic regRead, regWrite, regRvalid, regWack, bridgeEnable;
	logic [3:0] temps, shorts, chopperOffTime;
	logic [1:0] openLoad;
	logic [4:0] csActual;
	logic [6:0] regAddr;
	logic [31:0] regRdata, d;
	int fails, num_checks, st;
	dsf_driver_status_flags #(.STANDSTILL_CYCLES(SS)) dsf_driver_status_flags_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .stepPin(stepPin), .driverEnablePinN(driverEnablePinN),
		.chopperOffTime(chopperOffTime), .quietChopper(quietChopper), .csActual(csActual),
		.otSelect(otSelect), .tempLevelTop(temps[3]), .tempLevelHigh(temps[2]),
		.tempLevelMid(temps[1]), .tempLevelLow(temps[0]), .lowsideShortPhaseB(shorts[3]),
		.lowsideShortPhaseA(shorts[2]), .groundShortPhaseB(shorts[1]),
		.groundShortPhaseA(shorts[0]), .openLoadPhaseB(openLoad[1]),
		.openLoadPhaseA(openLoad[0]), .regAddr(regAddr), .regRead(regRead),
		.regWrite(regWrite), .regRdata(regRdata), .regRvalid(regRvalid), .regWack(regWack),
		.bridgeEnable(bridgeEnable));
	dsf_host_model dsf_host_model_inst (.ref_clk(ref_clk), .regAddr(regAddr),
		.regRead(regRead), .regWrite(regWrite), .chopperOffTime(chopperOffTime),
		.regRdata(regRdata), .regRvalid(regRvalid), .regWack(regWack));
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	function automatic logic [31:0] expWord(input logic ss, input logic [3:0] sh, input logic ot);
		return {ss, quietChopper, 9'h0, csActual, 4'h0, temps, openLoad, sh, ot,
			otSelect ? temps[1] : temps[0]};
	endfunction
	task automatic rd(input logic ss, input logic [3:0] sh, input logic ot);
		dsf_host_model_inst.access(ADDR_DRIVER_STATUS_FLAGS, 1'b0, d, ok);
		check("read ack", 32'(ok), 32'h1);
		check("status", d, expWord(ss, sh, ot));
	endtask
	task automatic waitBridge(input logic e);
		for (int i = 0; i < 20 && bridgeEnable !== e; i++) @(posedge ref_clk);
		check("bridge", 32'(bridgeEnable), 32'(e));
	endtask
	task automatic test_done;
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#200us;
		fails++;
		test_done();
	end
	initial begin
		{rst_n, stepPin, driverEnablePinN, quietChopper, otSelect} = 5'h00;
		{temps, shorts, openLoad, csActual} = 15'h0000;
		void'($urandom(98));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		waitBridge(1'b1);
		repeat (SS + 8) @(posedge ref_clk);
		rd(1'b1, 4'h0, 1'b0);
		dsf_host_model_inst.access(ADDR_DRIVER_STATUS_FLAGS, 1'b1, d, ok);
		check("write ack", 32'(ok), 32'h1);
		rd(1'b1, 4'h0, 1'b0);
		dsf_host_model_inst.access(7'h10, 1'b0, d, ok);
		check("unmapped", 32'(ok), 32'h0);
		for (int s = 0; s < 2; s++) begin
			otSelect <= s[0];
			temps <= s[0] ? 4'h6 : 4'h9;
			waitBridge(1'b0);
			rd(1'b1, 4'h0, 1'b1);
			temps <= s[0] ? 4'h2 : 4'h1;
			repeat (6) @(posedge ref_clk);
			rd(1'b1, 4'h0, 1'b1);
			waitBridge(1'b0);
			temps <= 4'h0;
			waitBridge(1'b1);
			rd(1'b1, 4'h0, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			quietChopper <= i[2];
			shorts[i[1:0]] <= 1'b1;
			waitBridge(1'b0);
			shorts <= 4'h0;
			repeat (4) @(posedge ref_clk);
			rd(1'b1, 4'h1 << i[1:0], 1'b0);
			quietChopper <= !i[2];
			rd(1'b1, 4'h0, 1'b0);
			quietChopper <= i[2];
			if (i[0]) driverEnablePinN <= 1'b1;
			else dsf_host_model_inst.setOffTime(4'h0);
			repeat (4) @(posedge ref_clk);
			rd(1'b1, 4'h0, 1'b0);
			driverEnablePinN <= 1'b0;
			dsf_host_model_inst.setOffTime(4'h3);
			waitBridge(1'b1);
		end
		for (int i = 0; i < 24; i++) begin
			quietChopper <= 1'($urandom);
			csActual <= 5'($urandom);
			otSelect <= 1'($urandom);
			openLoad <= 2'($urandom);
			temps <= {2'b00, 2'($urandom)};
			st = $urandom % 2;
			if (st != 0) begin
				stepPin <= 1'b1;
				@(posedge ref_clk);
				stepPin <= 1'b0;
				repeat (8) @(posedge ref_clk);
			end else begin
				repeat (SS + 8) @(posedge ref_clk);
			end
			rd(st == 0, 4'h0, 1'b0);
			check("bridge", 32'(bridgeEnable), 32'h1);
		end
		test_done();
	end
endmodule
bind dsf_driver_status_flags dsf_driver_status_flags_assertions dsf_chk_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .chopperOffTime(chopperOffTime),
	.quietChopper(quietChopper), .csActual(csActual), .openLoadPhaseB(openLoadPhaseB),
	.openLoadPhaseA(openLoadPhaseA), .regAddr(regAddr), .regRead(regRead),
	.regWrite(regWrite), .regRdata(regRdata), .regRvalid(regRvalid), .regWack(regWack),
	.bridgeEnable(bridgeEnable));
